// file: slcd_cfg.svh
// slcd_cfg.svh: register map, field positions, reset values and counts of the lcd drive block
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH
// register byte offsets
`define SLCD_OFS_CLKS   6'h00
`define SLCD_OFS_SUPPLY 6'h04
`define SLCD_OFS_LOWPWR 6'h08
`define SLCD_OFS_MAIN   6'h0C
`define SLCD_OFS_BLINK  6'h10
`define SLCD_OFS_FPEN0  6'h14
`define SLCD_OFS_STATUS 6'h2C
`define SLCD_NUM_FPEN   6
// lcd_clock_select fields
`define SLCD_CLKS_SRC   7
`define SLCD_CLKS_PRESCALE_BY_SIXTEEN 6
`define SLCD_CLKS_ADJ   5:0
// lcd_power_supply_control fields
`define SLCD_SUP_CPEN   7
`define SLCD_SUP_CPMS   6
`define SLCD_SUP_HDRV   5
`define SLCD_SUP_CHARGE_PUMP_CLOCK_ADJUST 4:3
`define SLCD_SUP_BYPASS 2
`define SLCD_SUP_VSEL   1:0
// lcd_low_power_control fields
`define SLCD_LP_WAIT    1
`define SLCD_LP_STATE_A   0
// lcd_main_control fields
`define SLCD_MAIN_EN    7
`define SLCD_MAIN_FCS   5:3
`define SLCD_MAIN_LPW   2
`define SLCD_MAIN_DUTY  1:0
// lcd_blink_control fields
`define SLCD_BLK_EN     7
`define SLCD_BLK_MODE   3
`define SLCD_BLK_RATE   2:0
// field codes and reset value
`define SLCD_VSEL_INT   2'h0
`define SLCD_DUTY_QUAD  2'h3
`define SLCD_RST_REG    8'h00
// divider counts
`define SLCD_PRE_LAST   4'hF
`define SLCD_BLINK_BASE 4'h4
// bus responses
`define SLCD_RESP_OKAY  2'h0
`define SLCD_RESP_SLV   2'h2
`endif

// file: slcd_pkg.sv
// slcd_pkg.sv: types shared by the lcd drive block
package slcd_pkg;
    // driver state, one-hot
    typedef enum logic [2:0] {
        SLCD_ST_OFF  = 3'h1,
        SLCD_ST_RUN  = 3'h2,
        SLCD_ST_HOLD = 3'h4
    } slcd_state_t;
    // supply and charge-pump controls to the analog part
    typedef struct packed {
        logic       cp_enable;
        logic       cp_tripler;
        logic [1:0] cp_clk_adj;
        logic       high_drive;
        logic       bias_unbuffered;
        logic       bias2_internal;
        logic [1:0] supply_sel;
    } slcd_pwr_t;
    // timing and blanking controls to the waveform generator
    typedef struct packed {
        logic [3:0] bp_select;
        logic       frame_start;
        logic       low_power_wave;
        logic       blank_all;
        logic       blank_selected;
    } slcd_disp_t;
endpackage

// file: slcd_drive_cfg.sv
// slcd_drive_cfg.sv: register file, clock dividers and pin control of the segment lcd driver
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "slcd_cfg.svh"

module slcd_drive_cfg #(
    parameter int NUM_FP = 41
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    // axi4-lite write channels
    input  wire logic                i_awvalid,
    output logic                     o_awready,
    input  wire logic [5:0]          i_awaddr,
    input  wire logic                i_wvalid,
    output logic                     o_wready,
    input  wire logic [31:0]         i_wdata,
    input  wire logic [3:0]          i_wstrb,
    output logic                     o_bvalid,
    input  wire logic                i_bready,
    output logic [1:0]               o_bresp,
    // axi4-lite read channels
    input  wire logic                i_arvalid,
    output logic                     o_arready,
    input  wire logic [5:0]          i_araddr,
    output logic                     o_rvalid,
    input  wire logic                i_rready,
    output logic [31:0]              o_rdata,
    output logic [1:0]               o_rresp,
    // system state and external lcd reference
    input  wire logic                i_wait_mode,
    input  wire logic                i_state_a_mode,
    input  wire logic                i_ext_ref_tick,
    // glass and analog controls
    output slcd_pkg::slcd_pwr_t      o_pwr,
    output slcd_pkg::slcd_disp_t     o_disp,
    output logic [NUM_FP-1:0]        o_fp_oe,
    output logic [NUM_FP-1:0]        o_fp_owned,
    output logic                     o_bp_oe,
    output logic                     o_active
);

    // reset release and registers
    logic                     rst_meta_reg;
    logic                     rst_n_reg;
    logic [7:0]               clks_reg;
    logic [7:0]               supply_reg;
    logic [7:0]               lowpwr_reg;
    logic [7:0]               main_reg;
    logic [7:0]               blink_reg;
    logic [7:0]               fpen_reg [`SLCD_NUM_FPEN];
    logic [8*`SLCD_NUM_FPEN-1:0] fp_flat;
    logic [NUM_FP-1:0]        fp_en_vec;
    // bus slave state
    logic                     aw_got_reg;
    logic                     w_got_reg;
    logic [5:0]               waddr_reg;
    logic [7:0]               wdata_reg;
    logic                     wstrb_reg;
    logic                     wr_go;
    logic                     wr_do;
    logic [7:0]               rd_val;
    // dividers and sequencing
    slcd_pkg::slcd_state_t    state_reg;
    slcd_pkg::slcd_state_t    state_next;
    logic                     active;
    logic                     lcd_tick;
    logic                     pre_tick;
    logic                     base_tick;
    logic                     phase_tick;
    logic                     frame_tick;
    logic                     blink_flip;
    logic [3:0]               pre_cnt_reg;
    logic [5:0]               adj_cnt_reg;
    logic [7:0]               fdiv_cnt_reg;
    logic [1:0]               bp_idx_reg;
    logic [15:0]              blk_cnt_reg;
    logic                     blink_phase_reg;
    logic [7:0]               fmask;
    logic [15:0]              bmask;

    // aligned word address
    function automatic logic [5:0] word_addr(input logic [5:0] a);
        return {a[5:2], 2'h0};
    endfunction

    // true for any word of the map
    function automatic logic is_mapped(input logic [5:0] a);
        return word_addr(a) <= `SLCD_OFS_STATUS;
    endfunction

    // true for a frontplane enable word
    function automatic logic is_fpen(input logic [5:0] a);
        return word_addr(a) >= `SLCD_OFS_FPEN0 && word_addr(a) < `SLCD_OFS_STATUS;
    endfunction

    // index of a frontplane enable word
    function automatic logic [2:0] fpen_idx(input logic [5:0] a);
        logic [5:0] d;
        d = word_addr(a) - `SLCD_OFS_FPEN0;
        return d[4:2];
    endfunction

    // low-ones mask for a power-of-two divider
    function automatic logic [15:0] pow2_mask(input logic [3:0] s);
        return (16'h1 << s) - 16'h1;
    endfunction

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // write channels: address and data taken in either order
    assign o_awready = !aw_got_reg && !o_bvalid;
    assign o_wready  = !w_got_reg && !o_bvalid;
    assign wr_go     = aw_got_reg && w_got_reg;
    assign wr_do     = wr_go && wstrb_reg;

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            aw_got_reg <= 1'b0;
            waddr_reg  <= 6'h00;
        end else if (i_awvalid && o_awready) begin
            aw_got_reg <= 1'b1;
            waddr_reg  <= i_awaddr;
        end else if (wr_go) begin
            aw_got_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            w_got_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb_reg <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= i_wdata[7:0];
            wstrb_reg <= i_wstrb[0];
        end else if (wr_go) begin
            w_got_reg <= 1'b0;
        end
    end

    // write response, unmapped words answer slverr
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `SLCD_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= is_mapped(waddr_reg) ? `SLCD_RESP_OKAY : `SLCD_RESP_SLV;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // register writes, only byte lane 0 carries data
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            clks_reg   <= `SLCD_RST_REG;
            supply_reg <= `SLCD_RST_REG;
            lowpwr_reg <= `SLCD_RST_REG;
            main_reg   <= `SLCD_RST_REG;
            blink_reg  <= `SLCD_RST_REG;
            for (int i = 0; i < `SLCD_NUM_FPEN; i++) begin
                fpen_reg[i] <= `SLCD_RST_REG;
            end
        end else if (wr_do) begin
            case (word_addr(waddr_reg))
                `SLCD_OFS_CLKS:   clks_reg   <= wdata_reg;
                `SLCD_OFS_SUPPLY: supply_reg <= wdata_reg;
                `SLCD_OFS_LOWPWR: lowpwr_reg <= wdata_reg;
                `SLCD_OFS_MAIN:   main_reg   <= wdata_reg;
                `SLCD_OFS_BLINK:  blink_reg  <= wdata_reg;
                default: begin
                    if (is_fpen(waddr_reg)) begin
                        fpen_reg[fpen_idx(waddr_reg)] <= wdata_reg;
                    end
                end
            endcase
        end
    end

    // read data selection, reads have no side effects
    always_comb begin
        rd_val = 8'h00;
        case (word_addr(i_araddr))
            `SLCD_OFS_CLKS:   rd_val = clks_reg;
            `SLCD_OFS_SUPPLY: rd_val = supply_reg;
            `SLCD_OFS_LOWPWR: rd_val = lowpwr_reg;
            `SLCD_OFS_MAIN:   rd_val = main_reg;
            `SLCD_OFS_BLINK:  rd_val = blink_reg;
            `SLCD_OFS_STATUS: rd_val = {4'h0, bp_idx_reg, blink_phase_reg, active};
            default: begin
                if (is_fpen(i_araddr)) begin
                    rd_val = fpen_reg[fpen_idx(i_araddr)];
                end
            end
        endcase
    end

    // read channel
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `SLCD_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= {24'h00_0000, rd_val};
            o_rresp  <= is_mapped(i_araddr) ? `SLCD_RESP_OKAY : `SLCD_RESP_SLV;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // one enable bit per frontplane pin
    always_comb begin
        for (int i = 0; i < `SLCD_NUM_FPEN; i++) begin
            fp_flat[i*8 +: 8] = fpen_reg[i];
        end
    end
    assign fp_en_vec = fp_flat[NUM_FP-1:0];

    // driver state from enable and low-power states
    always_comb begin
        case (state_reg)
            slcd_pkg::SLCD_ST_OFF,
            slcd_pkg::SLCD_ST_RUN,
            slcd_pkg::SLCD_ST_HOLD: begin
                if (!main_reg[`SLCD_MAIN_EN]) begin
                    state_next = slcd_pkg::SLCD_ST_OFF;
                end else if ((i_wait_mode && lowpwr_reg[`SLCD_LP_WAIT])
                          || (i_state_a_mode && lowpwr_reg[`SLCD_LP_STATE_A])) begin
                    state_next = slcd_pkg::SLCD_ST_HOLD;
                end else begin
                    state_next = slcd_pkg::SLCD_ST_RUN;
                end
            end
            default: state_next = slcd_pkg::SLCD_ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= slcd_pkg::SLCD_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active = state_next == slcd_pkg::SLCD_ST_RUN;

    assign lcd_tick  = active && (clks_reg[`SLCD_CLKS_SRC] ? 1'b1 : i_ext_ref_tick);
    assign pre_tick  = lcd_tick && (!clks_reg[`SLCD_CLKS_PRESCALE_BY_SIXTEEN] || pre_cnt_reg == `SLCD_PRE_LAST);
    assign base_tick = pre_tick && adj_cnt_reg >= clks_reg[`SLCD_CLKS_ADJ];

    // clock dividers restart whenever their setting is written
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pre_cnt_reg <= 4'h0;
            adj_cnt_reg <= 6'h00;
        end else if (wr_do && word_addr(waddr_reg) == `SLCD_OFS_CLKS) begin
            pre_cnt_reg <= 4'h0;
            adj_cnt_reg <= 6'h00;
        end else begin
            if (lcd_tick) begin
                pre_cnt_reg <= pre_cnt_reg + 4'h1;
            end
            if (base_tick) begin
                adj_cnt_reg <= 6'h00;
            end else if (pre_tick) begin
                adj_cnt_reg <= adj_cnt_reg + 6'h01;
            end
        end
    end

    // frame select divides base clock into backplane phases
    assign fmask      = 8'(pow2_mask({1'b0, main_reg[`SLCD_MAIN_FCS]}));
    assign phase_tick = base_tick && (fdiv_cnt_reg & fmask) == fmask;
    assign frame_tick = phase_tick && bp_idx_reg >= main_reg[`SLCD_MAIN_DUTY];

    // frame divider and backplane index restart on a main write
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fdiv_cnt_reg <= 8'h00;
            bp_idx_reg   <= 2'h0;
        end else if (wr_do && word_addr(waddr_reg) == `SLCD_OFS_MAIN) begin
            fdiv_cnt_reg <= 8'h00;
            bp_idx_reg   <= 2'h0;
        end else begin
            if (base_tick) begin
                fdiv_cnt_reg <= fdiv_cnt_reg + 8'h01;
            end
            if (frame_tick) begin
                bp_idx_reg <= 2'h0;
            end else if (phase_tick) begin
                bp_idx_reg <= bp_idx_reg + 2'h1;
            end
        end
    end

    // blink half period counted in base clocks
    assign bmask      = pow2_mask(4'({1'b0, blink_reg[`SLCD_BLK_RATE]}) + `SLCD_BLINK_BASE);
    assign blink_flip = base_tick && (blk_cnt_reg & bmask) == bmask;

    // blink phase, 1 shows segments and 0 blanks them
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            blk_cnt_reg     <= 16'h0000;
            blink_phase_reg <= 1'b1;
        end else if (!blink_reg[`SLCD_BLK_EN]) begin
            blk_cnt_reg     <= 16'h0000;
            blink_phase_reg <= 1'b1;
        end else if (base_tick) begin
            blk_cnt_reg <= blk_cnt_reg + 16'h0001;
            if (blink_flip) begin
                blink_phase_reg <= !blink_phase_reg;
            end
        end
    end

    // registered supply controls
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_pwr <= '0;
        end else begin
            // pump runs while enabled and driving
            o_pwr.cp_enable       <= supply_reg[`SLCD_SUP_CPEN] && active;
            // mode select ignored on internal supply
            o_pwr.cp_tripler      <= supply_reg[`SLCD_SUP_VSEL] != `SLCD_VSEL_INT
                                     && supply_reg[`SLCD_SUP_CPMS];
            o_pwr.cp_clk_adj      <= supply_reg[`SLCD_SUP_CHARGE_PUMP_CLOCK_ADJUST];
            o_pwr.high_drive      <= supply_reg[`SLCD_SUP_HDRV];
            o_pwr.bias_unbuffered <= supply_reg[`SLCD_SUP_BYPASS];
            // internal supply makes second bias level
            o_pwr.bias2_internal  <= supply_reg[`SLCD_SUP_VSEL] == `SLCD_VSEL_INT;
            o_pwr.supply_sel      <= supply_reg[`SLCD_SUP_VSEL];
        end
    end

    // registered display timing and pin enables
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_disp     <= '0;
            o_fp_oe    <= '0;
            o_fp_owned <= '0;
            o_bp_oe    <= 1'b0;
            o_active   <= 1'b0;
        end else begin
            o_disp.bp_select      <= active ? 4'h1 << bp_idx_reg : 4'h0;
            o_disp.frame_start    <= frame_tick;
            o_disp.low_power_wave <= main_reg[`SLCD_MAIN_LPW];
            // blank all or selected segments in the off half
            o_disp.blank_all      <= blink_reg[`SLCD_BLK_EN] && blink_reg[`SLCD_BLK_MODE]
                                     && !blink_phase_reg;
            o_disp.blank_selected <= blink_reg[`SLCD_BLK_EN] && !blink_reg[`SLCD_BLK_MODE]
                                     && !blink_phase_reg;
            o_fp_oe    <= active ? fp_en_vec : '0;
            // clear bits leave pins to other functions
            o_fp_owned <= fp_en_vec;
            o_bp_oe    <= active;
            o_active   <= active;
        end
    end

    // checks on the driver behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_reg);

    sequence s_quad_last;
        phase_tick && bp_idx_reg == 2'h3 && main_reg[`SLCD_MAIN_DUTY] == `SLCD_DUTY_QUAD;
    endsequence

    sequence s_frame_wrap;
        frame_tick ##1 (bp_idx_reg == 2'h0);
    endsequence

    src_bus_a: assert property (
        active && clks_reg[`SLCD_CLKS_SRC] && !clks_reg[`SLCD_CLKS_PRESCALE_BY_SIXTEEN]
        && clks_reg[`SLCD_CLKS_ADJ] == 6'h00 |-> base_tick)
        else $error("bus clock source does not tick the base clock");
    ext_ref_a: assert property (
        !clks_reg[`SLCD_CLKS_SRC] && !i_ext_ref_tick |-> !base_tick)
        else $error("base clock ticked without external reference");
    prescale_gap_a: assert property (
        base_tick && clks_reg[`SLCD_CLKS_PRESCALE_BY_SIXTEEN] |=> !base_tick [*8])
        else $error("prescale by sixteen not applied");
    pump_on_a: assert property (
        supply_reg[`SLCD_SUP_CPEN] && active |=> o_pwr.cp_enable)
        else $error("charge pump not enabled");
    tripler_int_a: assert property (
        supply_reg[`SLCD_SUP_VSEL] == `SLCD_VSEL_INT |=> !o_pwr.cp_tripler && o_pwr.bias2_internal)
        else $error("internal supply settings wrong");
    wait_off_a: assert property (
        i_wait_mode && lowpwr_reg[`SLCD_LP_WAIT] |=> !o_active && o_fp_oe == '0)
        else $error("glass driven in wait state");
    state_a_on_a: assert property (
        main_reg[`SLCD_MAIN_EN] && !i_wait_mode && i_state_a_mode
        && !lowpwr_reg[`SLCD_LP_STATE_A] |=> o_active)
        else $error("glass not driven in state_a state");
    quad_frame_a: assert property (
        s_quad_last |-> s_frame_wrap)
        else $error("quarter duty frame does not wrap after four backplanes");
    fcs_zero_a: assert property (
        base_tick && main_reg[`SLCD_MAIN_FCS] == 3'h0 |-> phase_tick)
        else $error("frame select zero does not pass base clock");
    blink_all_a: assert property (
        blink_reg[`SLCD_BLK_EN] && blink_reg[`SLCD_BLK_MODE] && !blink_phase_reg
        |=> o_disp.blank_all && !o_disp.blank_selected)
        else $error("blink all not applied");
    blink_step_a: assert property (
        blink_reg[`SLCD_BLK_EN] && !base_tick |=> $stable(blink_phase_reg))
        else $error("blink phase moved without base clock");
    fp_gate_a: assert property (
        1'b1 |=> (o_fp_oe & ~$past(fp_en_vec)) == '0)
        else $error("disabled frontplane driven");

endmodule // slcd_drive_cfg

// file: slcd_glass_model.sv
// glass panel model: times frames and notes which backplanes were driven
`timescale 1ns/1ps
module slcd_glass_model (
    input  wire logic                 i_clk,
    input  wire logic                 i_clear,
    input  wire slcd_pkg::slcd_disp_t i_disp,
    input  wire logic                 i_bp_oe,
    output int                        o_period,
    output int                        o_frames,
    output logic [3:0]                o_bp_seen
);
    int cnt = 0;
    // frame spacing in clock cycles, backplanes seen only while driven
    always @(posedge i_clk) begin
        cnt <= i_disp.frame_start ? 1 : cnt + 1;
        if (i_disp.frame_start)
            o_period <= cnt;
        if (i_clear) begin
            o_frames  <= 0;
            o_bp_seen <= 4'h0;
        end else begin
            o_frames  <= o_frames + int'(i_disp.frame_start);
            o_bp_seen <= o_bp_seen | (i_bp_oe ? i_disp.bp_select : 4'h0);
        end
    end
endmodule // slcd_glass_model

// file: slcd_drive_cfg_test.sv
// self-checking bench of the lcd drive configuration block
`timescale 1ns/1ps
`include "slcd_cfg.svh"
module slcd_drive_cfg_test;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, clr = 1;
    logic wait_m = 0, stop_m = 0, tick = 0, tick_en = 0, awready, wready, bvalid;
    logic arready, rvalid, bp_oe, active;
    logic [1:0]  bresp, rresp;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [40:0] fp_oe, fp_own;
    slcd_pkg::slcd_pwr_t  pwr;
    slcd_pkg::slcd_disp_t disp;
    int period, frames, err_total = 0, tests_run = 0, seed = 51;
    logic [3:0] bp_seen;
    slcd_drive_cfg i_slcd_drive_cfg (.i_clk(clk), .i_resetn(rstn), .i_awvalid(awv),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bre), .o_bresp(bresp),
        .i_arvalid(arv), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(rre), .o_rdata(rdata), .o_rresp(rresp), .i_wait_mode(wait_m),
        .i_state_a_mode(stop_m), .i_ext_ref_tick(tick), .o_pwr(pwr), .o_disp(disp),
        .o_fp_oe(fp_oe), .o_fp_owned(fp_own), .o_bp_oe(bp_oe), .o_active(active));
    slcd_glass_model i_slcd_glass_model (.i_clk(clk), .i_clear(clr), .i_disp(disp),
        .i_bp_oe(bp_oe), .o_period(period), .o_frames(frames), .o_bp_seen(bp_seen));
    // clock, external reference ticks and watchdog
    always #5 clk = ~clk;
    always @(posedge clk) tick <= tick_en & $random(seed);
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    // write: address and data offered together, each released once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awv <= 1;
        wv <= 1;
        awaddr <= a;
        wdata <= {24'h0, d};
        bre <= 1;
        forever begin
            @(negedge clk);
            ta = awv && awready;
            tw = wv && wready;
            tb = bvalid;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tb) begin
                bre <= 0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        arv <= 1;
        araddr <= a;
        rre <= 1;
        forever begin
            @(negedge clk);
            ta = arv && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
            if (tr) begin
                rre <= 0;
                break;
            end
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [63:0] fp;
        logic [7:0]  v;
        int          ex, hp, tl;
        logic        sa, ss, b, pv;
        repeat (8) @(posedge clk);
        rstn <= 1;
        clr <= 0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            v = $random(seed);
            rd(6'(4 * i), d, r);
            chk("reset value", d, 0);
            wr(6'(4 * i), v);
            rd(6'(4 * i), d, r);
            chk("readback", d, {24'h0, v});
        end
        rd(6'h30, d, r);
        chk("unmapped resp", r, `SLCD_RESP_SLV);
        chk("unmapped data", d, 0);
        $display("register test done");
        wr(`SLCD_OFS_LOWPWR, 8'h00);
        wr(`SLCD_OFS_MAIN, 8'h83);
        for (int n = 0; n < 8; n++) begin
            v = $random(seed);
            wr(`SLCD_OFS_SUPPLY, v);
            repeat (3) @(negedge clk);
            chk("pump enable", pwr.cp_enable, v[7]);
            chk("pump mode", pwr.cp_tripler, v[6] && v[1:0] != 2'h0);
            chk("bias bypass", pwr.bias_unbuffered, v[2]);
            chk("second bias", pwr.bias2_internal, v[1:0] == 2'h0);
            chk("supply select", pwr.supply_sel, v[1:0]);
            chk("pump clock", pwr.cp_clk_adj, v[4:3]);
        end
        $display("power test done");
        for (int n = 0; n < 3; n++) begin
            ex = (n == 1 ? 16 : 1) * (1 + 2 * n + n * n) * (4 << n);
            wr(`SLCD_OFS_CLKS, {1'b1, n == 1, 6'(2 * n + n * n)});
            wr(`SLCD_OFS_MAIN, {2'b10, 3'(n), 3'b011});
            // fresh backplane record for this setting
            clr <= 1;
            @(posedge clk);
            clr <= 0;
            repeat (3 * ex + 20) @(negedge clk);
            chk("frame period", period, ex);
            chk("backplanes", bp_seen, 4'hF);
        end
        wr(`SLCD_OFS_CLKS, 8'h00);
        wr(`SLCD_OFS_MAIN, 8'h83);
        clr <= 1;
        repeat (300) @(negedge clk);
        chk("external idle", frames, 0);
        clr <= 0;
        tick_en <= 1;
        repeat (300) @(negedge clk);
        chk("external runs", frames > 20, 1);
        $display("clock test done");
        fp = {$random(seed), $random(seed)};
        for (int k = 0; k < 6; k++)
            wr(`SLCD_OFS_FPEN0 + 6'(4 * k), fp[8 * k +: 8]);
        wr(`SLCD_OFS_LOWPWR, 8'h02);
        for (int m = 0; m < 5; m++) begin
            @(posedge clk);
            wait_m <= m[0];
            stop_m <= m[1];
            repeat (3) @(negedge clk);
            chk("active", active, !m[0]);
            chk("bp driven", bp_oe, !m[0]);
            chk("fp driven", fp_oe, m[0] ? 41'h0 : fp[40:0]);
            chk("fp owned", fp_own, fp[40:0]);
        end
        $display("pin test done");
        wr(`SLCD_OFS_CLKS, 8'h80);
        for (int n = 0; n < 4; n++) begin
            wr(`SLCD_OFS_BLINK, {1'b1, 3'h0, n[0], 2'h0, n[1]});
            {sa, ss, pv, tl, hp} = '0;
            for (int c = 0; c < 300; c++) begin
                @(negedge clk);
                sa |= disp.blank_all;
                ss |= disp.blank_selected;
                b = disp.blank_all | disp.blank_selected;
                if (b != pv) begin
                    hp = c - tl;
                    tl = c;
                end
                pv = b;
            end
            chk("blink all", sa, n[0]);
            chk("blink selected", ss, !n[0]);
            chk("blink half period", hp, 16 << n[1]);
        end
        $display("blink test done");
        finish_test();
    end
endmodule // slcd_drive_cfg_test
